// ===== core/tcc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.vh"

module tcc_top (
   // Clock, reset, enable
   input wire CLK,
   input wire RST_N,
   input wire CE,
   // AHB-Lite slave
   input wire HSEL,
   input wire [7:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output reg HREADYOUT,
   output reg HRESP,
   // Channel 0 pin
   input wire CH0_PIN_I,
   output wire CH0_PIN_O,
   output reg CH0_PIN_OE,
   // Channel 1 pin
   input wire CH1_PIN_I,
   output wire CH1_PIN_O,
   output reg CH1_PIN_OE,
   // Interrupt request
   output reg IRQ
);

   //-------------------------------------------------------------------
   // Functions
   //-------------------------------------------------------------------
   // Mode from the two select bits; buffered wins
   function [1:0] mode_of;
      input msb;
      input msa;
      begin
         if (msb) begin
            mode_of = `TCC_MODE_BUF;
         end else if (msa) begin
            mode_of = `TCC_MODE_CMP;
         end else begin
            mode_of = `TCC_MODE_CAP;
         end
      end
   endfunction

   // Qualify a synchronised pin edge against the edge select
   function cap_hit;
      input [1:0] els;
      input cur;
      input prev;
      begin
         case (els)
            `TCC_ELS_RISE: cap_hit = cur & ~prev;
            `TCC_ELS_FALL: cap_hit = ~cur & prev;
            `TCC_ELS_BOTH: cap_hit = cur ^ prev;
            default: cap_hit = 1'b0;
         endcase
      end
   endfunction

   // Pack a status/control byte for reads
   function [31:0] sc_word;
      input flag;
      input ie;
      input msb;
      input msa;
      input [1:0] els;
      input tov;
      input full;
      reg [31:0] w;
      begin
         w = `TCC_WORD_ZERO;
         w[`TCC_SC_FLAG] = flag;
         w[`TCC_SC_IE] = ie;
         w[`TCC_SC_MSB] = msb;
         w[`TCC_SC_MSA] = msa;
         w[`TCC_SC_ELSH] = els[1];
         w[`TCC_SC_ELSL] = els[0];
         w[`TCC_SC_TOV] = tov;
         w[`TCC_SC_MAX] = full;
         sc_word = w;
      end
   endfunction

   //-------------------------------------------------------------------
   // Declarations
   //-------------------------------------------------------------------
   reg [`TCC_CNT_W-1:0] cnt_q, mod_q, val0_q, val1_q;
   reg flag0_q, flag1_q, ie0_q, ie1_q;
   reg msb0_q, msa0_q, msa1_q;
   reg [1:0] els0_q, els1_q;
   reg tov0_q, tov1_q, max0_q, max1_q;
   reg act_q, last_q, wr_pend_q;
   reg [7:0] wr_addr_q;
   reg s0a_q, s0b_q, s0c_q, s1a_q, s1b_q, s1c_q;
   reg [2:0] prime_q;
   reg [31:0] rd_d;

   wire [1:0] mode0, mode1;
   wire link, cmp0_on, cmp1_on, cap0_on, cap1_on, wrap;
   wire [`TCC_CNT_W-1:0] cmp0;
   wire match0, match1, cap0, cap1, set0, set1, acc;
   wire wr_sc0, wr_sc1, wr_val0, wr_val1, wr_mod, clr0, clr1;

   //-------------------------------------------------------------------
   // Mode decode
   //-------------------------------------------------------------------
   assign mode0 = mode_of(msb0_q, msa0_q);
   assign mode1 = mode_of(1'b0, msa1_q);
   assign link = (mode0 == `TCC_MODE_BUF);
   assign cmp0_on = (mode0 != `TCC_MODE_CAP);
   assign cmp1_on = !link && (mode1 == `TCC_MODE_CMP);
   assign cap0_on = (mode0 == `TCC_MODE_CAP);
   assign cap1_on = !link && (mode1 == `TCC_MODE_CAP);

   //-------------------------------------------------------------------
   // Counter
   //-------------------------------------------------------------------
   assign wrap = (cnt_q == mod_q);

   always @(posedge CLK) begin
      if (!RST_N) begin
         cnt_q <= `TCC_CNT_ZERO;
      end else if (CE) begin
         if (wrap) begin
            cnt_q <= `TCC_CNT_ZERO;
         end else begin
            cnt_q <= cnt_q + `TCC_CNT_ONE;
         end
      end
   end

   //-------------------------------------------------------------------
   // Pin synchronisers
   //-------------------------------------------------------------------
   always @(posedge CLK) begin
      if (!RST_N) begin
         s0a_q <= 1'b0;
         s0b_q <= 1'b0;
         s0c_q <= 1'b0;
         s1a_q <= 1'b0;
         s1b_q <= 1'b0;
         s1c_q <= 1'b0;
         prime_q <= {3{1'b0}};
      end else if (CE) begin
         prime_q <= {prime_q[1:0], 1'b1};
         s0a_q <= CH0_PIN_I;
         s0b_q <= s0a_q;
         s0c_q <= s0b_q;
         s1a_q <= CH1_PIN_I;
         s1b_q <= s1a_q;
         s1c_q <= s1b_q;
      end
   end

   // Edges are ignored until the synchroniser holds real pin levels
   assign cap0 = cap0_on && prime_q[2] &&
                 cap_hit(els0_q, s0b_q, s0c_q);
   assign cap1 = cap1_on && prime_q[2] &&
                 cap_hit(els1_q, s1b_q, s1c_q);

   //-------------------------------------------------------------------
   // Buffered pair selection
   //-------------------------------------------------------------------
   assign cmp0 = (link && act_q) ? val1_q : val0_q;

   always @(posedge CLK) begin
      if (!RST_N) begin
         act_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         if (!link) begin
            act_q <= 1'b0;
            last_q <= 1'b0;
         end else begin
            if (wr_val1) begin
               last_q <= 1'b1;
            end else if (wr_val0) begin
               last_q <= 1'b0;
            end
            if (CE && wrap) begin
               act_q <= last_q;
            end
         end
      end
   end

   //-------------------------------------------------------------------
   // Channel output logic
   //-------------------------------------------------------------------
   tcc_chan u_chan0 (
      .clk(CLK),
      .rst_n(RST_N),
      .ce(CE),
      .active(cmp0_on),
      .els(els0_q),
      .tov(tov0_q),
      .full(max0_q),
      .cnt(cnt_q),
      .cmp(cmp0),
      .wrap(wrap),
      .match(match0),
      .pin_q(CH0_PIN_O)
   );

   tcc_chan u_chan1 (
      .clk(CLK),
      .rst_n(RST_N),
      .ce(CE),
      .active(cmp1_on),
      .els(els1_q),
      .tov(tov1_q),
      .full(max1_q),
      .cnt(cnt_q),
      .cmp(val1_q),
      .wrap(wrap),
      .match(match1),
      .pin_q(CH1_PIN_O)
   );

   always @(posedge CLK) begin
      if (!RST_N) begin
         CH0_PIN_OE <= 1'b0;
         CH1_PIN_OE <= 1'b0;
      end else begin
         CH0_PIN_OE <= cmp0_on && (els0_q != `TCC_ELS_NONE);
         CH1_PIN_OE <= cmp1_on && (els1_q != `TCC_ELS_NONE);
      end
   end

   //-------------------------------------------------------------------
   // Bus decode
   //-------------------------------------------------------------------
   assign acc = HSEL && HTRANS[1] && HREADY;
   assign wr_mod = wr_pend_q && (wr_addr_q == `TCC_OFS_MOD);
   assign wr_sc0 = wr_pend_q && (wr_addr_q == `TCC_OFS_SC0);
   assign wr_val0 = wr_pend_q && (wr_addr_q == `TCC_OFS_VAL0);
   assign wr_sc1 = wr_pend_q && !link && (wr_addr_q == `TCC_OFS_SC1);
   assign wr_val1 = wr_pend_q && (wr_addr_q == `TCC_OFS_VAL1);
   assign clr0 = wr_sc0 && !HWDATA[`TCC_SC_FLAG];
   assign clr1 = wr_sc1 && !HWDATA[`TCC_SC_FLAG];

   always @(posedge CLK) begin
      if (!RST_N) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= `TCC_OFS_CNT;
         HRDATA <= `TCC_WORD_ZERO;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         wr_pend_q <= acc && HWRITE;
         if (acc) begin
            wr_addr_q <= HADDR;
         end
         if (acc && !HWRITE) begin
            HRDATA <= rd_d;
         end
      end
   end

   always @* begin
      rd_d = `TCC_WORD_ZERO;
      case (HADDR)
         `TCC_OFS_CNT: rd_d[`TCC_CNT_W-1:0] = cnt_q;
         `TCC_OFS_MOD: rd_d[`TCC_CNT_W-1:0] = mod_q;
         `TCC_OFS_SC0: rd_d = sc_word(flag0_q, ie0_q, msb0_q, msa0_q,
                                      els0_q, tov0_q, max0_q);
         `TCC_OFS_VAL0: rd_d[`TCC_CNT_W-1:0] = val0_q;
         `TCC_OFS_SC1: rd_d = sc_word(flag1_q, ie1_q, 1'b0, msa1_q,
                                      els1_q, tov1_q, max1_q);
         `TCC_OFS_VAL1: rd_d[`TCC_CNT_W-1:0] = val1_q;
         `TCC_OFS_LINK: begin
            rd_d[`TCC_LK_ACT] = act_q;
            rd_d[`TCC_LK_LAST] = last_q;
         end
         default: rd_d = `TCC_WORD_ZERO;
      endcase
   end

   //-------------------------------------------------------------------
   // Control registers
   //-------------------------------------------------------------------
   always @(posedge CLK) begin
      if (!RST_N) begin
         mod_q <= `TCC_MOD_RST;
         ie0_q <= 1'b0;
         msb0_q <= 1'b0;
         msa0_q <= 1'b0;
         els0_q <= `TCC_ELS_NONE;
         tov0_q <= 1'b0;
         max0_q <= 1'b0;
         ie1_q <= 1'b0;
         msa1_q <= 1'b0;
         els1_q <= `TCC_ELS_NONE;
         tov1_q <= 1'b0;
         max1_q <= 1'b0;
      end else begin
         if (wr_mod) begin
            mod_q <= HWDATA[`TCC_CNT_W-1:0];
         end
         if (wr_sc0) begin
            ie0_q <= HWDATA[`TCC_SC_IE];
            msb0_q <= HWDATA[`TCC_SC_MSB];
            msa0_q <= HWDATA[`TCC_SC_MSA];
            els0_q <= HWDATA[`TCC_SC_ELSH:`TCC_SC_ELSL];
            tov0_q <= HWDATA[`TCC_SC_TOV];
            max0_q <= HWDATA[`TCC_SC_MAX];
         end
         if (wr_sc1) begin
            ie1_q <= HWDATA[`TCC_SC_IE];
            msa1_q <= HWDATA[`TCC_SC_MSA];
            els1_q <= HWDATA[`TCC_SC_ELSH:`TCC_SC_ELSL];
            tov1_q <= HWDATA[`TCC_SC_TOV];
            max1_q <= HWDATA[`TCC_SC_MAX];
         end
      end
   end

   //-------------------------------------------------------------------
   // Channel value registers (no reset)
   //-------------------------------------------------------------------
   always @(posedge CLK) begin
      if (CE && cap0) begin
         val0_q <= cnt_q;
      end else if (wr_val0) begin
         val0_q <= HWDATA[`TCC_CNT_W-1:0];
      end
      if (CE && cap1) begin
         val1_q <= cnt_q;
      end else if (wr_val1) begin
         val1_q <= HWDATA[`TCC_CNT_W-1:0];
      end
   end

   //-------------------------------------------------------------------
   // Event flags and interrupt
   //-------------------------------------------------------------------
   assign set0 = CE && (cap0 || match0);
   assign set1 = CE && (cap1 || match1);

   always @(posedge CLK) begin
      if (!RST_N) begin
         flag0_q <= 1'b0;
         flag1_q <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         flag0_q <= set0 || (flag0_q && !clr0);
         flag1_q <= set1 || (flag1_q && !clr1);
         IRQ <= (flag0_q && ie0_q) || (flag1_q && ie1_q);
      end
   end

endmodule
`default_nettype wire

// ===== core/tcc_defines.vh
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
// Notes on behaviour
// - Active pin edge copies counter into capture
// - Capture happens whether flag set or clear
// - Captured value appears three cycles after edge
// - Set flag requests interrupt only when enabled
// - Later capture overwrites earlier captured value
// - Reset leaves channel value registers untouched
// - Capture and compare share one counter
// - Compare match sets, clears or toggles pin
// - Unbuffered write replaces compare value immediately
// - Buffered select links channels onto pin zero
// - Last written pair takes control at wrap
// - Linked mode frees channel one pin, control
// - Toggle on wrap forms the PWM period
// - Pulse width is wrap to compare time
// - Full duty bit forces high next period with toggle on wrap and clear on match
// - Without toggle on wrap, only compare match changes output
// - Buffered select overrides unbuffered select
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

`define TCC_CNT_W 16

// Register byte offsets
`define TCC_OFS_CNT 8'h00
`define TCC_OFS_MOD 8'h04
`define TCC_OFS_SC0 8'h08
`define TCC_OFS_VAL0 8'h0C
`define TCC_OFS_SC1 8'h10
`define TCC_OFS_VAL1 8'h14
`define TCC_OFS_LINK 8'h18

// Status/control bit positions
`define TCC_SC_FLAG 7
`define TCC_SC_IE 6
`define TCC_SC_MSB 5
`define TCC_SC_MSA 4
`define TCC_SC_ELSH 3
`define TCC_SC_ELSL 2
`define TCC_SC_TOV 1
`define TCC_SC_MAX 0

// Link status bit positions
`define TCC_LK_ACT 0
`define TCC_LK_LAST 1

// Edge/level codes
`define TCC_ELS_NONE 2'h0
`define TCC_ELS_TOGGLE 2'h1
`define TCC_ELS_CLEAR 2'h2
`define TCC_ELS_SET 2'h3
`define TCC_ELS_RISE 2'h1
`define TCC_ELS_FALL 2'h2
`define TCC_ELS_BOTH 2'h3

// Channel modes
`define TCC_MODE_CAP 2'h0
`define TCC_MODE_CMP 2'h1
`define TCC_MODE_BUF 2'h2

// Reset and constant values
`define TCC_MOD_RST 16'hFFFF
`define TCC_CNT_ZERO 16'h0000
`define TCC_CNT_ONE 16'h0001
`define TCC_WORD_ZERO 32'h0000_0000

`endif

// ===== core/tcc_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.vh"

module tcc_chan (
   // Clock and control
   input wire clk,
   input wire rst_n,
   input wire ce,
   // Channel set-up
   input wire active,
   input wire [1:0] els,
   input wire tov,
   input wire full,
   // Counter
   input wire [`TCC_CNT_W-1:0] cnt,
   input wire [`TCC_CNT_W-1:0] cmp,
   input wire wrap,
   // Results
   output wire match,
   output reg pin_q
);

   reg full_q;
   wire force_hi;

   assign match = active & (cnt == cmp);
   assign force_hi = tov & (els == `TCC_ELS_CLEAR);

   //-------------------------------------------------------------------
   // Output action
   //-------------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         pin_q <= 1'b0;
         full_q <= 1'b0;
      end else if (ce) begin
         if (wrap) begin
            full_q <= full;
         end
         if (active) begin
            if (wrap && tov) begin
               if (full && force_hi) begin
                  pin_q <= 1'b1;
               end else begin
                  pin_q <= ~pin_q;
               end
            end else if (match && !(full_q && force_hi)) begin
               case (els)
                  `TCC_ELS_TOGGLE: pin_q <= ~pin_q;
                  `TCC_ELS_CLEAR: pin_q <= 1'b0;
                  `TCC_ELS_SET: pin_q <= 1'b1;
                  default: pin_q <= pin_q;
               endcase
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== dv/tcc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_chk (
   // Clock and control
   input wire CLK,
   input wire RST_N,
   input wire CE,
   // Bus
   input wire HSEL,
   input wire [7:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   input wire [31:0] HRDATA,
   input wire HREADYOUT,
   input wire HRESP,
   // Pins and request
   input wire CH0_PIN_O,
   input wire CH0_PIN_OE,
   input wire CH1_PIN_O,
   input wire CH1_PIN_OE,
   input wire IRQ
);
   //----------------------------------------------------------------
   // Shadow of the control bits, loaded in the write data phase
   //----------------------------------------------------------------
   logic wr_q;
   logic ie1_q;
   logic [7:0] a_q;
   logic [7:0] sc0_q;
   wire take = HSEL && HTRANS[1] && HREADY;
   wire cap0 = sc0_q[5:4] == 2'b00;
   wire drv0 = !cap0 && sc0_q[3:2] != 2'b00;
   always @(posedge CLK) begin
      if (!RST_N) begin
         wr_q <= 1'b0;
         ie1_q <= 1'b0;
         a_q <= 8'h00;
         sc0_q <= 8'h00;
      end else begin
         wr_q <= take && HWRITE;
         a_q <= HADDR;
         if (wr_q && a_q == 8'h08)
            sc0_q <= HWDATA[7:0];
         if (wr_q && a_q == 8'h10 && !sc0_q[5])
            ie1_q <= HWDATA[6];
      end
   end
   //----------------------------------------------------------------
   // Properties
   //----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_ready_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus slave stalled or erred");
   a_rdata_hold: assert property (
      !$past(take && !HWRITE) |-> $stable(HRDATA))
      else $error("read data moved without a read");
   a_ce_freeze: assert property (
      !$past(CE) |-> $stable(CH0_PIN_O) && $stable(CH1_PIN_O))
      else $error("pin moved while counter clock held");
   a_link_frees: assert property (
      sc0_q[5] && $past(sc0_q[5]) |-> !CH1_PIN_OE)
      else $error("second pin driven while linked");
   a_irq_gated: assert property (IRQ |-> $past(sc0_q[6] || ie1_q))
      else $error("request raised with enables off");
   a_cap_no_drive: assert property (
      cap0 && $past(cap0) |-> !CH0_PIN_OE)
      else $error("capture channel drives its pin");
   a_oe_needs_mode: assert property (
      CH0_PIN_OE |-> drv0 || $past(drv0))
      else $error("pin driven without an output action");
   a_no_rise: assert property (
      $rose(CH0_PIN_O) && CH0_PIN_OE |-> $past(sc0_q[1] || sc0_q[2]))
      else $error("pin rose with clear only and no wrap toggle");
   c_write: cover property (take && HWRITE);
   c_irq: cover property ($rose(IRQ));
   c_pin: cover property ($rose(CH0_PIN_O));
endmodule
bind tcc_top tcc_chk u_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CH0_PIN_O(CH0_PIN_O),
   .CH0_PIN_OE(CH0_PIN_OE), .CH1_PIN_O(CH1_PIN_O),
   .CH1_PIN_OE(CH1_PIN_OE), .IRQ(IRQ));
`default_nettype wire

// ===== dv/tcc_pins.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_pins (
   // Outside sources
   input wire ext0,
   input wire ext1,
   // Block side
   input wire o0,
   input wire oe0,
   input wire o1,
   input wire oe1,
   // Resolved pin levels
   output wire pin0,
   output wire pin1
);
   // Block wins while it drives, else the outside source
   assign pin0 = oe0 ? o0 : ext0;
   assign pin1 = oe1 ? o1 : ext1;
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic [31:0] hwdata = 32'h0000_0000;
   logic ext0 = 1'b0;
   logic ext1 = 1'b0;
   wire [31:0] rdata;
   wire rdy, resp, p0, p1, o0, oe0, o1, oe1, irq;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [15:0] mc, mod_m, v0_m, v1_m, cv, cnt_s;
   logic [6:0] sc0_m = 7'h00;
   logic [6:0] sc1_m = 7'h00;
   logic act_m, last_m, pm, flq, fl;
   logic [1:0] e, lnk_s;
   logic [31:0] r;
   logic [7:0] cfg [7] = '{8'h14, 8'h18, 8'h1C, 8'h1A, 8'h1B, 8'h1A, 8'h1E};
   logic [7:0] ra [5] = '{8'h04, 8'h08, 8'h10, 8'h18, 8'h1C};

   always #12.5 clk = ~clk;

   tcc_top DUT (.CLK(clk), .RST_N(rst_n), .CE(ce), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HWDATA(hwdata), .HREADY(rdy), .HRDATA(rdata), .HREADYOUT(rdy),
      .HRESP(resp), .CH0_PIN_I(p0), .CH0_PIN_O(o0), .CH0_PIN_OE(oe0),
      .CH1_PIN_I(p1), .CH1_PIN_O(o1), .CH1_PIN_OE(oe1), .IRQ(irq));
   tcc_pins u_pins (.ext0(ext0), .ext1(ext1), .o0(o0), .oe0(oe0),
      .o1(o1), .oe1(oe1), .pin0(p0), .pin1(p1));

   //----------------------------------------------------------------
   // Reference model of counter and channel 0 pin
   //----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         mc <= 16'h0000;
         mod_m <= 16'hFFFF;
         {act_m, last_m, pm, flq} <= 4'h0;
      end else if (ce) begin
         mc <= (mc == mod_m) ? 16'h0000 : mc + 16'h0001;
         e = sc0_m[3:2];
         cv = (sc0_m[5] && act_m) ? v1_m : v0_m;
         fl = sc0_m[0] && sc0_m[1] && e == 2'h2;
         if (mc == mod_m) begin
            flq <= fl;
            if (sc0_m[5])
               act_m <= last_m;
         end
         if (sc0_m[5:4] != 2'h0) begin
            if (mc == mod_m && sc0_m[1])
               pm <= fl | ~pm;
            else if (mc == cv && e != 2'h0 && !(flq && e == 2'h2))
               pm <= (e == 2'h1) ? ~pm : e[0];
         end
      end
   end

   always @(negedge clk)
      if (rst_n && oe0 === 1'b1)
         chk("pin0", {31'h0, pm}, {31'h0, o0});

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end

   //----------------------------------------------------------------
   // Tasks
   //----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] x,
         input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (rdy !== 1'b1);
      cnt_s = mc;
      lnk_s = {last_m, act_m};
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      q = rdata;
      if (w) begin
         case (a)
            8'h04: mod_m <= d[15:0];
            8'h08: begin
               if (d[5] && !sc0_m[5])
                  {act_m, last_m} <= 2'h0;
               sc0_m <= d[6:0];
            end
            8'h0C: v0_m <= d[15:0];
            8'h10: if (!sc0_m[5]) sc1_m <= d[6:0] & 7'h5F;
            8'h14: v1_m <= d[15:0];
         endcase
         if (sc0_m[5] && (a == 8'h0C || a == 8'h14))
            last_m <= a[4];
      end
   endtask

   task automatic cap(input int ch, input logic lv);
      logic [15:0] x;
      if (ch == 1)
         ext1 <= lv;
      else
         ext0 <= lv;
      repeat (3) @(posedge clk);
      x = mc;
      bus(1'b0, (ch == 1) ? 8'h14 : 8'h0C, 32'h0, r);
      chk("capture", {16'h0, x}, {16'h0, r[15:0]});
   endtask

   task automatic run(input int n);
      repeat (n) begin
         @(posedge clk);
         ce <= ($urandom_range(0, 3) != 0);
      end
   endtask

   task results;
      if (n_fail == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   //----------------------------------------------------------------
   // Main sequence
   //----------------------------------------------------------------
   initial begin
      void'($urandom(86));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b1, 8'h00, 32'h0000_1234, r);
      bus(1'b1, 8'h1C, 32'hFFFF_FFFF, r);
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, ra[i], 32'h0, r);
         chk("reset", (i == 0) ? 32'h0000_FFFF : 32'h0, r);
      end
      bus(1'b1, 8'h04, 32'h0000_00FF, r);
      bus(1'b0, 8'h00, 32'h0, r);
      chk("count", {16'h0, cnt_s}, r);
      bus(1'b1, 8'h08, 32'h0000_0044, r);
      repeat (2) begin
         ext0 <= 1'b0;
         repeat ($urandom_range(3, 20)) @(posedge clk);
         cap(0, 1'b1);
         chk("irq", 32'h1, {31'h0, irq});
      end
      bus(1'b1, 8'h08, 32'h0000_0044, r);
      repeat (2) @(posedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      ext1 <= 1'b1;
      bus(1'b1, 8'h10, 32'h0000_0008, r);
      cap(1, 1'b0);
      bus(1'b1, 8'h10, 32'h0000_000C, r);
      cap(1, 1'b1);
      chk("irq", 32'h0, {31'h0, irq});
      bus(1'b1, 8'h10, 32'h0000_001C, r);
      for (int i = 0; i < 7; i++) begin
         r = (i == 3) ? 32'h0000_00FF : $urandom_range(0, 255);
         bus(1'b1, 8'h0C, r, r);
         bus(1'b1, 8'h08, 32'(cfg[i]), r);
         run(300);
         bus(1'b1, 8'h0C, $urandom_range(0, 255), r);
         run(300);
      end
      chk("pin1", 32'h1, {31'h0, o1});
      chk("oe1 on", 32'h1, {31'h0, oe1});
      bus(1'b1, 8'h08, 32'h0000_003A, r);
      bus(1'b1, 8'h14, $urandom_range(0, 255), r);
      for (int i = 0; i < 2; i++) begin
         bus(1'b0, 8'h18, 32'h0, r);
         chk("link", {30'h0, lnk_s}, r);
         run(600);
      end
      bus(1'b1, 8'h10, 32'h0000_00FF, r);
      bus(1'b0, 8'h10, 32'h0, r);
      chk("sc1", {25'h0, sc1_m}, {25'h0, r[6:0]});
      chk("oe1", 32'h0, {31'h0, oe1});
      bus(1'b1, 8'h0C, $urandom_range(0, 255), r);
      run(600);
      bus(1'b0, 8'h18, 32'h0, r);
      chk("link", {30'h0, lnk_s}, r);
      results();
   end
endmodule
`default_nettype wire
